// ==== src/dma_regs_pkg.sv ====
// constants for the dma control register block: offsets, codes, reset values
// assumes a single 50 MHz fabric clock and word-wide register access
`default_nettype none
package dma_regs_pkg;
  localparam logic [19:0] OFF_SCRATCH    = 20'h00000;
  localparam logic [19:0] OFF_DIRECTION  = 20'h08008;
  localparam logic [19:0] OFF_LENGTH     = 20'h08010;
  localparam logic [19:0] OFF_CYCLES     = 20'h08018;
  localparam logic [19:0] OFF_DONE       = 20'h08020;
  localparam logic [19:0] OFF_HOST_BASE  = 20'h08028;
  localparam logic [19:0] OFF_BLINK      = 20'h08030;
  localparam logic [19:0] OFF_DIP        = 20'h13080;
  localparam logic [19:0] OFF_LED        = 20'h13088;

  localparam logic [31:0] DIR_SRAM_TO_HOST = 32'h11aa1111;
  localparam logic [31:0] DIR_HOST_TO_SRAM = 32'h11aa2222;
  localparam logic [31:0] LEN_8K           = 32'h00002000;
  localparam logic [31:0] LEN_16K          = 32'h00004000;
  localparam logic [31:0] LEN_32K          = 32'h00008000;
  localparam logic [31:0] BLINK_CODE       = 32'h11aa0f0f;

  localparam int unsigned BURST_BYTES = 32;
  localparam int unsigned WORD_BYTES  = 4;
  localparam int unsigned BURST_WORDS = BURST_BYTES / WORD_BYTES;

  localparam logic [31:0] RST_WORD  = 32'h00000000;
  localparam logic [7:0]  RST_LED   = 8'h00;
  localparam logic [31:0] RST_DONE  = 32'h00000001;
  localparam logic [31:0] RST_LEN   = 32'h00002000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_DATA,
    ST_WRITE,
    ST_NEXT
  } mover_state_t;
endpackage
`default_nettype wire

// ==== src/word_fifo.sv ====
// word fifo between the link side and the memory side of the mover
// assumes both sides on one clock; push ignored when full, pop when empty
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== src/dma_ctrl_regs.sv ====
// control and status registers of the host-driven dma mover, plus the mover
// assumes a simple word register port from the link endpoint, a burst read/write
// master toward host memory on the link, and a word port to on-chip sram
`default_nettype none
module dma_ctrl_regs #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // register port from the link endpoint
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [19:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // link burst master toward host memory
  output logic             o_link_req,
  output logic             o_link_write,
  output logic [31:0]      o_link_addr,
  input  wire logic        i_link_gnt,
  input  wire logic        i_link_rvalid,
  input  wire logic [31:0] i_link_rdata,
  output logic             o_link_wvalid,
  output logic [31:0]      o_link_wdata,
  input  wire logic        i_link_wready,
  // on-chip sram word port
  output logic             o_sram_en,
  output logic             o_sram_we,
  output logic [14:0]      o_sram_addr,
  output logic [31:0]      o_sram_wdata,
  input  wire logic [31:0] i_sram_rdata,
  // board pins
  input  wire logic [3:0]  i_dip_switch,
  output logic [7:0]       o_led_drive_bits,
  output logic             o_led_blink_request
);
  logic [31:0] scratch_reg;
  logic [31:0] dir_reg;
  logic [31:0] len_reg;
  logic [31:0] cycles_reg;
  logic        done_reg;
  logic [31:0] base_reg;
  logic [31:0] blink_reg;
  logic [7:0]  led_reg;
  logic [3:0]  dip_meta_reg;
  logic [3:0]  dip_reg;
  logic [31:0] rdata_reg;
  logic        rvalid_reg;

  dma_regs_pkg::mover_state_t state_reg;
  logic        to_host_reg;
  logic [31:0] bytes_left_reg;
  logic [31:0] offset_reg;
  logic [3:0]  beat_reg;
  logic        rd_pend_reg;
  logic        start;
  logic        dir_ok;
  logic        fifo_in_valid;
  logic [31:0] fifo_in_data;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic        fifo_out_ready;

  function automatic logic hit(input logic [19:0] a, input logic [19:0] off);
    return a == off;
  endfunction

  // unsupported lengths fall back to 8k rather than overrun the sram
  function automatic logic [31:0] legal_len(input logic [31:0] v);
    if (v == dma_regs_pkg::LEN_16K || v == dma_regs_pkg::LEN_32K) begin
      return v;
    end
    return dma_regs_pkg::LEN_8K;
  endfunction

  assign dir_ok = i_reg_wdata == dma_regs_pkg::DIR_SRAM_TO_HOST
               || i_reg_wdata == dma_regs_pkg::DIR_HOST_TO_SRAM;
  assign start  = i_reg_wr && hit(i_reg_addr, dma_regs_pkg::OFF_DIRECTION) && dir_ok
               && state_reg == dma_regs_pkg::ST_IDLE;

  // register writes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      scratch_reg <= dma_regs_pkg::RST_WORD;
      dir_reg     <= dma_regs_pkg::RST_WORD;
      len_reg     <= dma_regs_pkg::RST_LEN;
      base_reg    <= dma_regs_pkg::RST_WORD;
      blink_reg   <= dma_regs_pkg::RST_WORD;
      led_reg     <= dma_regs_pkg::RST_LED;
    end else if (i_reg_wr) begin
      if (hit(i_reg_addr, dma_regs_pkg::OFF_SCRATCH)) begin
        scratch_reg <= i_reg_wdata;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_DIRECTION)) begin
        dir_reg <= i_reg_wdata;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_LENGTH)) begin
        len_reg <= i_reg_wdata;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_HOST_BASE)) begin
        base_reg <= i_reg_wdata;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_BLINK)) begin
        blink_reg <= i_reg_wdata;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_LED)) begin
        led_reg <= i_reg_wdata[7:0];
      end
    end
  end

  // board pins
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      dip_meta_reg        <= 4'h0;
      dip_reg             <= 4'h0;
      o_led_drive_bits    <= dma_regs_pkg::RST_LED;
      o_led_blink_request <= 1'b0;
    end else begin
      dip_meta_reg        <= i_dip_switch;
      dip_reg             <= dip_meta_reg;
      o_led_drive_bits    <= led_reg;
      o_led_blink_request <= blink_reg == dma_regs_pkg::BLINK_CODE;
    end
  end

  // reads: one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rdata_reg  <= dma_regs_pkg::RST_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= i_reg_rd;
      if (hit(i_reg_addr, dma_regs_pkg::OFF_SCRATCH)) begin
        rdata_reg <= scratch_reg;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_DIRECTION)) begin
        rdata_reg <= dir_reg;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_LENGTH)) begin
        rdata_reg <= len_reg;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_CYCLES)) begin
        rdata_reg <= cycles_reg;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_DONE)) begin
        rdata_reg <= {31'h0, done_reg};
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_HOST_BASE)) begin
        rdata_reg <= base_reg;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_BLINK)) begin
        rdata_reg <= blink_reg;
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_DIP)) begin
        rdata_reg <= {20'h0, dip_reg, 8'h0};
      end else if (hit(i_reg_addr, dma_regs_pkg::OFF_LED)) begin
        rdata_reg <= {24'h0, led_reg};
      end else begin
        rdata_reg <= 32'h0;
      end
    end
  end
  assign o_reg_rdata  = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

  // cycle counter and done flag
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cycles_reg <= dma_regs_pkg::RST_WORD;
      done_reg   <= dma_regs_pkg::RST_DONE[0];
    end else if (start) begin
      cycles_reg <= 32'h0;
      done_reg   <= 1'b0;
    end else if (state_reg != dma_regs_pkg::ST_IDLE) begin
      cycles_reg <= cycles_reg + 32'h1;
      if (state_reg == dma_regs_pkg::ST_NEXT && bytes_left_reg == 32'h0) begin
        done_reg <= 1'b1;
      end
    end
  end

  // mover: one burst per link packet; the fifo decouples link and sram rates
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_reg      <= dma_regs_pkg::ST_IDLE;
      to_host_reg    <= 1'b0;
      bytes_left_reg <= 32'h0;
      offset_reg     <= 32'h0;
      beat_reg       <= 4'h0;
      rd_pend_reg    <= 1'b0;
    end else begin
      case (state_reg)
        dma_regs_pkg::ST_IDLE: begin
          if (start) begin
            to_host_reg    <= i_reg_wdata == dma_regs_pkg::DIR_SRAM_TO_HOST;
            bytes_left_reg <= legal_len(len_reg);
            offset_reg     <= 32'h0;
            beat_reg       <= 4'h0;
            rd_pend_reg    <= 1'b0;
            state_reg      <= dma_regs_pkg::ST_REQ;
          end
        end
        dma_regs_pkg::ST_REQ: begin
          if (i_link_gnt) begin
            beat_reg  <= 4'h0;
            state_reg <= to_host_reg ? dma_regs_pkg::ST_WRITE : dma_regs_pkg::ST_DATA;
          end
        end
        dma_regs_pkg::ST_DATA: begin
          // host to sram: link beats fill fifo, fifo drains into sram
          if (i_link_rvalid && fifo_in_ready) begin
            beat_reg <= beat_reg + 4'h1;
          end
          if (beat_reg == 4'(dma_regs_pkg::BURST_WORDS) && !fifo_out_valid) begin
            state_reg <= dma_regs_pkg::ST_NEXT;
          end
        end
        dma_regs_pkg::ST_WRITE: begin
          // sram to host: fetch words into fifo, fifo drains onto link
          rd_pend_reg <= o_sram_en;
          if (o_sram_en) begin
            beat_reg <= beat_reg + 4'h1;
          end
          if (beat_reg == 4'(dma_regs_pkg::BURST_WORDS) && !rd_pend_reg
              && !fifo_out_valid) begin
            state_reg <= dma_regs_pkg::ST_NEXT;
          end
        end
        dma_regs_pkg::ST_NEXT: begin
          if (bytes_left_reg == 32'h0) begin
            state_reg <= dma_regs_pkg::ST_IDLE;
          end else begin
            state_reg <= dma_regs_pkg::ST_REQ;
          end
        end
        default: state_reg <= dma_regs_pkg::ST_IDLE;
      endcase
      if (state_reg == dma_regs_pkg::ST_REQ && i_link_gnt) begin
        bytes_left_reg <= bytes_left_reg - 32'(dma_regs_pkg::BURST_BYTES);
      end
      if (state_reg == dma_regs_pkg::ST_NEXT) begin
        offset_reg <= offset_reg + 32'(dma_regs_pkg::BURST_BYTES);
      end
    end
  end

  assign o_link_req    = state_reg == dma_regs_pkg::ST_REQ;
  assign o_link_write  = to_host_reg;
  assign o_link_addr   = base_reg + offset_reg;

  // read-ahead stalls when the fifo cannot take the returning word
  logic        sram_fetch;
  logic [31:0] sram_word_addr;
  logic [3:0]  sram_wcnt_reg;
  assign sram_fetch = state_reg == dma_regs_pkg::ST_WRITE && fifo_in_ready && !rd_pend_reg
                   && beat_reg != 4'(dma_regs_pkg::BURST_WORDS);
  assign sram_word_addr = offset_reg + {26'h0, beat_reg, 2'b00};

  assign fifo_in_valid = to_host_reg ? rd_pend_reg
                       : (state_reg == dma_regs_pkg::ST_DATA && i_link_rvalid);
  assign fifo_in_data  = to_host_reg ? i_sram_rdata : i_link_rdata;
  assign fifo_out_ready = to_host_reg ? i_link_wready : 1'b1;

  assign o_link_wvalid = to_host_reg && fifo_out_valid;
  assign o_link_wdata  = fifo_out_data;
  assign o_sram_en     = sram_fetch || (!to_host_reg && fifo_out_valid);
  assign o_sram_we     = !to_host_reg && fifo_out_valid;
  assign o_sram_wdata  = fifo_out_data;
  assign o_sram_addr   = to_host_reg ? sram_word_addr[14:0]
                       : (offset_reg[14:0] + {9'h0, sram_wcnt_reg, 2'b00});

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || state_reg == dma_regs_pkg::ST_REQ) begin
      sram_wcnt_reg <= 4'h0;
    end else if (o_sram_we) begin
      sram_wcnt_reg <= sram_wcnt_reg + 4'h1;
    end
  end

  word_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) data_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (fifo_in_valid),
    .i_in_data   (fifo_in_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_out_ready)
  );
endmodule
`default_nettype wire

// ==== testbench/dma_regs_checker.sv ====
// concurrent checks on the dma register block, seen from its ports only
// assumes one clock domain and host buffers aligned to the burst size
`default_nettype none
module dma_regs_checker (
  // clock, reset and register port
  input wire logic        i_ref_clk, i_rst_b, i_reg_wr, i_reg_rd, o_reg_rvalid,
  input wire logic [19:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata, o_reg_rdata,
  // link master and board pins
  input wire logic        o_link_req, o_link_write, i_link_gnt, o_link_wvalid, i_link_wready,
  input wire logic [31:0] o_link_addr, o_link_wdata,
  input wire logic        o_led_blink_request
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [2:0] beat_reg;
  logic       to_host_reg;
  wire logic  dir_wr = i_reg_wr && i_reg_addr == dma_regs_pkg::OFF_DIRECTION;
  wire logic  blink_wr = i_reg_wr && i_reg_addr == dma_regs_pkg::OFF_BLINK;
  // beats modulo a burst; zero means every burst so far was whole
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      beat_reg <= 3'h0;
    end else if (o_link_wvalid && i_link_wready) begin
      beat_reg <= beat_reg + 3'h1;
    end
  end
  // only valid codes move the expected direction
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      to_host_reg <= 1'b0;
    end else if (dir_wr && (i_reg_wdata == dma_regs_pkg::DIR_SRAM_TO_HOST
                            || i_reg_wdata == dma_regs_pkg::DIR_HOST_TO_SRAM)) begin
      to_host_reg <= i_reg_wdata == dma_regs_pkg::DIR_SRAM_TO_HOST;
    end
  end
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("register read not answered");
  rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without a read");
  // the pin trails the stored word by one more register stage
  blink_set_a: assert property (blink_wr |=> ##1
    o_led_blink_request == ($past(i_reg_wdata, 2) == dma_regs_pkg::BLINK_CODE))
    else $error("blink request does not follow the code");
  blink_hold_a: assert property (!blink_wr && !$past(blink_wr) |=>
    $stable(o_led_blink_request))
    else $error("blink request moved without a write");
  req_hold_a: assert property (o_link_req && !i_link_gnt |=>
    o_link_req && $stable(o_link_addr))
    else $error("burst request dropped or moved before grant");
  burst_align_a: assert property (o_link_req |-> o_link_addr[4:0] == 5'h00)
    else $error("burst address not on a burst boundary");
  beat_hold_a: assert property (o_link_wvalid && !i_link_wready |=>
    o_link_wvalid && $stable(o_link_wdata))
    else $error("write beat changed while stalled");
  burst_beats_a: assert property (i_link_gnt && o_link_write |-> beat_reg == 3'h0)
    else $error("write burst not eight beats");
  dir_select_a: assert property (o_link_req |-> o_link_write == to_host_reg)
    else $error("burst direction differs from code");
  busy_status_a: assert property (i_reg_rd && i_reg_addr == dma_regs_pkg::OFF_DONE
    && o_link_req |=> o_reg_rdata == 32'h00000000)
    else $error("done reads set while transfer outstanding");
  cover property (i_link_gnt && o_link_write);
  cover property (i_link_gnt && !o_link_write);
  cover property ($rose(o_led_blink_request));
  cover property (i_reg_rd && i_reg_addr == dma_regs_pkg::OFF_DONE && o_link_req);
endmodule
bind dma_ctrl_regs dma_regs_checker i_chk (.i_ref_clk, .i_rst_b, .i_reg_wr, .i_reg_rd,
  .o_reg_rvalid, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_link_req, .o_link_write,
  .i_link_gnt, .o_link_wvalid, .i_link_wready, .o_link_addr, .o_link_wdata,
  .o_led_blink_request);
`default_nettype wire

// ==== testbench/host_link_model.sv ====
// host memory behind the link plus the on-chip sram word array
// assumes 32 KB aligned buffers; host word at address a holds ~a
`default_nettype none
module host_link_model (
  // clock, reset, stall request from the bench
  input  wire logic        i_ref_clk, i_rst_b, i_slow,
  // link burst slave
  input  wire logic        i_link_req, i_link_write, i_link_wvalid,
  input  wire logic [31:0] i_link_addr, i_link_wdata,
  output logic             o_link_gnt, o_link_rvalid, o_link_wready,
  output logic [31:0]      o_link_rdata,
  // sram word port
  input  wire logic        i_sram_en, i_sram_we,
  input  wire logic [14:0] i_sram_addr,
  input  wire logic [31:0] i_sram_wdata,
  output logic [31:0]      o_sram_rdata
);
  logic [31:0] hmem [0:8191];
  logic [31:0] sram [0:8191];
  logic [31:0] burst_addr, last_addr;
  logic [2:0]  beats;
  logic        busy, wr_reg;
  int unsigned bursts;
  // write beats only taken inside a granted burst
  assign o_link_wready = busy && wr_reg && !i_slow;
  always_ff @(posedge i_ref_clk) begin
    o_link_gnt <= 1'b0;
    o_link_rvalid <= 1'b0;
    o_link_rdata <= ~o_link_rdata;
    if (!i_rst_b) begin
      busy <= 1'b0;
      bursts <= 0;
      o_link_rdata <= 32'h00000000;
    end else if (!busy) begin
      if (i_link_req && !o_link_gnt && !i_slow) begin
        o_link_gnt <= 1'b1;
        busy <= 1'b1;
        wr_reg <= i_link_write;
        burst_addr <= i_link_addr;
        last_addr <= i_link_addr;
        beats <= 3'h0;
        bursts <= bursts + 1;
      end
    end else if (!i_slow && (!wr_reg || i_link_wvalid)) begin
      if (wr_reg) begin
        hmem[burst_addr[14:2] + beats] <= i_link_wdata;
      end else begin
        o_link_rvalid <= 1'b1;
        o_link_rdata <= ~(burst_addr + {beats, 2'b00});
      end
      beats <= beats + 3'h1;
      busy <= beats != 3'h7;
    end
  end
  // read data only valid the cycle after enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_sram_rdata <= 32'h00000000;
    end else if (i_sram_en) begin
      if (i_sram_we) begin
        sram[i_sram_addr[14:2]] <= i_sram_wdata;
      end
      o_sram_rdata <= sram[i_sram_addr[14:2]];
    end else begin
      o_sram_rdata <= ~o_sram_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/dma_ctrl_regs_tb.sv ====
// self-checking bench: register access, board pins, transfers both ways
// assumes the host model answers the link and holds the sram array
`default_nettype none
module dma_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, slow = 1'b0;
  logic [19:0] i_reg_addr = 20'h00000;
  logic [31:0] i_reg_wdata = 32'h00000000;
  logic [3:0]  i_dip_switch = 4'h0;
  logic [31:0] o_reg_rdata, o_link_addr, o_link_wdata, o_sram_wdata, i_link_rdata, i_sram_rdata;
  logic        o_reg_rvalid, o_link_req, o_link_write, i_link_gnt, i_link_rvalid, o_link_wvalid;
  logic        i_link_wready, o_sram_en, o_sram_we, o_led_blink_request;
  logic [14:0] o_sram_addr;
  logic [7:0]  o_led_drive_bits;
  int          num_errors = 0, compares = 0, cycles = 0;
  logic [31:0] d, base;
  dma_ctrl_regs #(.FIFO_DEPTH(16)) i_dut (.i_ref_clk, .i_rst_b, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_link_req, .o_link_write,
    .o_link_addr, .i_link_gnt, .i_link_rvalid, .i_link_rdata, .o_link_wvalid, .o_link_wdata,
    .i_link_wready, .o_sram_en, .o_sram_we, .o_sram_addr, .o_sram_wdata, .i_sram_rdata,
    .i_dip_switch, .o_led_drive_bits, .o_led_blink_request);
  host_link_model i_host (.i_ref_clk, .i_rst_b, .i_slow(slow), .i_link_req(o_link_req),
    .i_link_write(o_link_write), .i_link_wvalid(o_link_wvalid), .i_link_addr(o_link_addr),
    .i_link_wdata(o_link_wdata), .o_link_gnt(i_link_gnt), .o_link_rvalid(i_link_rvalid),
    .o_link_wready(i_link_wready), .o_link_rdata(i_link_rdata), .i_sram_en(o_sram_en),
    .i_sram_we(o_sram_we), .i_sram_addr(o_sram_addr), .i_sram_wdata(o_sram_wdata),
    .o_sram_rdata(i_sram_rdata));
  always #10 i_ref_clk = ~i_ref_clk;
  // a quarter of cycles stall the host side
  always @(posedge i_ref_clk) begin
    slow <= $urandom_range(3) == 0;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [31:0] v);
    int n = 0;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1;
    while (o_reg_rvalid !== 1'b1 && n < 8) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    v = o_reg_rdata;
  endtask
  task automatic rchk(input string what, input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(what, exp, v);
  endtask
  task automatic xfer(input logic [31:0] dir, input logic [31:0] len, input logic [31:0] b);
    int n = 0;
    int b0 = i_host.bursts;
    int t0;
    logic [31:0] v;
    wr(dma_regs_pkg::OFF_HOST_BASE, b);
    wr(dma_regs_pkg::OFF_LENGTH, len);
    wr(dma_regs_pkg::OFF_DIRECTION, dir);
    t0 = cycles;
    rchk("done while busy", dma_regs_pkg::OFF_DONE, 32'h00000000);
    rd(dma_regs_pkg::OFF_CYCLES, v);
    check("cycle count cleared", 32'h1, {31'h0, v < 32'h10});
    v = 32'h0;
    while (v !== 32'h1 && n < 30000) begin
      rd(dma_regs_pkg::OFF_DONE, v);
      n++;
    end
    check("done after transfer", 32'h1, v);
    rd(dma_regs_pkg::OFF_CYCLES, v);
    check("cycle total", 32'h1, {31'h0, v >= len / 4 && v <= cycles - t0});
    rchk("cycle total frozen", dma_regs_pkg::OFF_CYCLES, v);
    check("burst count", len / 32, i_host.bursts - b0);
    check("last burst address", b + len - 32, i_host.last_addr);
    check("direction", {31'h0, dir == dma_regs_pkg::DIR_SRAM_TO_HOST}, {31'h0, i_host.wr_reg});
    $display("test transfer %h of %h bytes done", dir, len);
  endtask
  initial begin
    void'($urandom(80));
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rchk("done at reset", dma_regs_pkg::OFF_DONE, 32'h00000001);
    rchk("cycles at reset", dma_regs_pkg::OFF_CYCLES, 32'h00000000);
    rchk("length at reset", dma_regs_pkg::OFF_LENGTH, dma_regs_pkg::LEN_8K);
    check("led pins at reset", 32'h0, {24'h0, o_led_drive_bits});
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom();
      wr(dma_regs_pkg::OFF_SCRATCH, d);
      rchk("scratch", dma_regs_pkg::OFF_SCRATCH, d);
    end
    wr(20'h00004, 32'hdeadbeef);
    rchk("unmapped read", 20'h00004, 32'h00000000);
    rchk("scratch kept", dma_regs_pkg::OFF_SCRATCH, d);
    wr(dma_regs_pkg::OFF_CYCLES, 32'h12345678);
    rchk("cycles read only", dma_regs_pkg::OFF_CYCLES, 32'h00000000);
    $display("test scratch and access done");
    d = $urandom();
    wr(dma_regs_pkg::OFF_LED, d);
    @(posedge i_ref_clk);
    #1;
    check("led pins", {24'h0, d[7:0]}, {24'h0, o_led_drive_bits});
    for (int i = 0; i < 4; i++) begin
      d = (i % 2 == 0) ? dma_regs_pkg::BLINK_CODE
        : (i == 1) ? dma_regs_pkg::BLINK_CODE ^ 32'h00010000 : $urandom();
      wr(dma_regs_pkg::OFF_BLINK, d);
      @(posedge i_ref_clk);
      #1;
      check("blink pin", {31'h0, d == dma_regs_pkg::BLINK_CODE}, {31'h0, o_led_blink_request});
    end
    @(posedge i_ref_clk);
    i_dip_switch <= d[3:0];
    repeat (4) @(posedge i_ref_clk);
    rd(dma_regs_pkg::OFF_DIP, base);
    check("dip switches", {28'h0, d[3:0]}, {28'h0, base[11:8]});
    $display("test board pins done");
    wr(dma_regs_pkg::OFF_DIRECTION, 32'h11aa3333);
    repeat (4) @(posedge i_ref_clk);
    rchk("done after bad code", dma_regs_pkg::OFF_DONE, 32'h00000001);
    check("no burst on bad code", 32'h0, i_host.bursts);
    base = $urandom() & 32'hffff8000;
    xfer(dma_regs_pkg::DIR_HOST_TO_SRAM, dma_regs_pkg::LEN_8K, base);
    xfer(dma_regs_pkg::DIR_SRAM_TO_HOST, dma_regs_pkg::LEN_8K, base);
    for (int i = 0; i < 2048; i++) check("host word", ~(base + 4 * i), i_host.hmem[i]);
    xfer(dma_regs_pkg::DIR_SRAM_TO_HOST, dma_regs_pkg::LEN_16K, $urandom() & 32'hffff8000);
    base = $urandom() & 32'hffff8000;
    xfer(dma_regs_pkg::DIR_HOST_TO_SRAM, dma_regs_pkg::LEN_32K, base);
    for (int i = 0; i < 8192; i++) check("sram word", ~(base + 4 * i), i_host.sram[i]);
    summarize();
  end
endmodule
`default_nettype wire
